// *** sbt_params.svh ***
// constants for the memory boundary scan test port
`ifndef SBT_PARAMS_SVH
`define SBT_PARAMS_SVH
`define SBT_IR_W          3
`define SBT_ID_W          32
`define SBT_BSR_W         48
`define SBT_OE_CELL       47
`define SBT_RST_TMS_EDGES 5
`define SBT_IR_CAPTURE    2'h1
`define SBT_OP_EXTEST     3'h0
`define SBT_OP_IDCODE     3'h1
`define SBT_OP_SAMPLEZ    3'h2
`define SBT_OP_SAMPLE     3'h4
`define SBT_OP_BYPASS     3'h7
// identification fields: arbitrary values
`define SBT_ID_VERSION    3'h5
`define SBT_ID_PART       17'h00000
`define SBT_ID_MAKER      11'h000
`endif

// *** sbt_pkg.sv ***
// types for the memory boundary scan test port
package sbt_pkg;
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
    } sbt_state_t;
    typedef struct packed {
        logic tdo;
        logic tdo_oe;
    } sbt_tdo_t;
endpackage : sbt_pkg

// *** sbt_tap.sv ***
// boundary scan test port of the pipelined memory
//
// Behaviour
// - all test inputs sampled on rising test clock edge
// - data-out changes on falling edge, driven only while shifting
// - data-in enters selected register msb, data-out leaves its lsb
// - mode select and data-in default high when undriven
// - five rising edges with mode select high reset port, memory untouched
// - power-up reset leaves data-out high impedance
// - exactly one register in scan path, chosen by current instruction
// - instruction register is three bits, serially loaded
// - identification instruction loaded at power-up and in reset state
// - capture-ir loads 01 into two low instruction bits
// - bypass is one flip-flop, cleared when bypass executes
// - capture-dr loads memory pin states into boundary register, then shifts
// - boundary chain msb at data-in, lsb at data-out, fixed cell order
// - identification instruction captures hardwired 32-bit code then shifts
// - shifted instruction takes effect only at update-ir
// - high-impedance sample selects boundary register and floats output bus
// - cell 47 enables output bus under external test, preset high
// - bypass instruction routes shift-dr data through bypass bit
`timescale 1ns/1ps
`include "sbt_params.svh"
module sbt_tap
    import sbt_pkg::*;
#(
    parameter int BSR_W = `SBT_BSR_W
) (
    // core clock domain
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    // test link, own clock domain
    input  wire logic             tck_i,
    input  wire logic             tms_i,
    input  wire logic             tms_oe_i,
    input  wire logic             tdi_i,
    input  wire logic             tdi_oe_i,
    output sbt_tdo_t              tdo_o,
    // memory pin ring
    input  wire logic [BSR_W-1:0] pins_i,
    output logic      [BSR_W-1:0] bsr_out_o,
    output logic                  q_oe_o,
    output logic                  test_mode_o
);
    localparam logic [`SBT_ID_W-1:0] ID_VALUE = {`SBT_ID_VERSION, `SBT_ID_PART, `SBT_ID_MAKER, 1'b1}; // arbitrary id

    sbt_state_t              st_ff, nxt_st;
    logic [`SBT_IR_W-1:0]    ir_sh_ff, nxt_ir_sh, ir_ff, nxt_ir;
    logic                    byp_ff, nxt_byp;
    logic [`SBT_ID_W-1:0]    id_ff, nxt_id;
    logic [BSR_W-1:0]        bsr_ff, nxt_bsr, upd_ff, nxt_upd;
    logic                    tdo_ff, tdo_oe_ff, nxt_tdo, nxt_tdo_oe;
    logic                    tms, tdi, sel_bsr, tdo_bit;
    logic [2:0]              tms_hi_ff, nxt_tms_hi;
    logic [2:0]              lvl_src, lvl_q;
    logic                    ez_q, oe_q, tm_q;
    localparam logic [2:0]   LVL_RST = 3'h2; // only the output enable cell resets high


    assign tms = tms_oe_i ? tms_i : 1'b1;
    assign tdi = tdi_oe_i ? tdi_i : 1'b1;
    assign sel_bsr = (ir_ff == `SBT_OP_EXTEST) || (ir_ff == `SBT_OP_SAMPLE) || (ir_ff == `SBT_OP_SAMPLEZ);

    // next state of the controller
    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            ST_RESET:  nxt_st = tms ? ST_RESET : ST_IDLE;
            ST_IDLE:   nxt_st = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: nxt_st = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: nxt_st = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  nxt_st = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: nxt_st = tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: nxt_st = tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: nxt_st = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: nxt_st = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: nxt_st = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: nxt_st = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  nxt_st = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: nxt_st = tms ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: nxt_st = tms ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: nxt_st = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: nxt_st = tms ? ST_SEL_DR : ST_IDLE;
            default:   nxt_st = ST_RESET;
        endcase
    end

    // next values of the scan registers
    always_comb begin
        nxt_ir_sh  = ir_sh_ff;
        nxt_ir     = ir_ff;
        nxt_byp    = byp_ff;
        nxt_id     = id_ff;
        nxt_bsr    = bsr_ff;
        nxt_upd    = upd_ff;
        nxt_tms_hi = tms ? ((tms_hi_ff == 3'h7) ? 3'h7 : tms_hi_ff + 3'h1) : 3'h0;
        case (st_ff)
            ST_RESET: begin
                nxt_ir = `SBT_OP_IDCODE;
                nxt_upd[`SBT_OE_CELL] = 1'b1;
            end
            ST_CAP_IR: nxt_ir_sh = {ir_sh_ff[`SBT_IR_W-1:2], `SBT_IR_CAPTURE};
            ST_SH_IR:  nxt_ir_sh = {tdi, ir_sh_ff[`SBT_IR_W-1:1]};
            ST_UPD_IR: nxt_ir = ir_sh_ff;
            ST_CAP_DR: begin
                if (sel_bsr) nxt_bsr = pins_i;
                if (ir_ff == `SBT_OP_IDCODE) nxt_id = ID_VALUE;
                if (ir_ff == `SBT_OP_BYPASS || !sel_bsr && ir_ff != `SBT_OP_IDCODE) nxt_byp = 1'b0;
            end
            ST_SH_DR: begin
                if (sel_bsr) nxt_bsr = {tdi, bsr_ff[BSR_W-1:1]};
                else if (ir_ff == `SBT_OP_IDCODE) nxt_id = {tdi, id_ff[`SBT_ID_W-1:1]};
                else nxt_byp = tdi;
            end
            ST_UPD_DR: if (sel_bsr) nxt_upd = bsr_ff;
            default: nxt_ir = ir_ff;
        endcase
        if (st_ff != ST_RESET && tms_hi_ff == 3'(`SBT_RST_TMS_EDGES - 1) && tms) begin
            nxt_ir = ir_ff;
        end
    end

    // registers on the rising test clock edge, power-up reset included
    always_ff @(posedge tck_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff     <= ST_RESET;
            ir_sh_ff  <= `SBT_OP_IDCODE;
            ir_ff     <= `SBT_OP_IDCODE;
            byp_ff    <= 1'b0;
            id_ff     <= '0;
            bsr_ff    <= '0;
            upd_ff    <= BSR_W'(1) << `SBT_OE_CELL;
            tms_hi_ff <= 3'h0;
        end else begin
            st_ff     <= nxt_st;
            ir_sh_ff  <= nxt_ir_sh;
            ir_ff     <= nxt_ir;
            byp_ff    <= nxt_byp;
            id_ff     <= nxt_id;
            bsr_ff    <= nxt_bsr;
            upd_ff    <= nxt_upd;
            tms_hi_ff <= nxt_tms_hi;
        end
    end

    // serial output source, lsb of the selected register
    always_comb begin
        tdo_bit = byp_ff;
        if (st_ff == ST_SH_IR) tdo_bit = ir_sh_ff[0];
        else if (sel_bsr) tdo_bit = bsr_ff[0];
        else if (ir_ff == `SBT_OP_IDCODE) tdo_bit = id_ff[0];
    end

    // next values of the falling edge output stage
    always_comb begin
        nxt_tdo    = tdo_bit;
        nxt_tdo_oe = (st_ff == ST_SH_IR) || (st_ff == ST_SH_DR);
    end

    // falling edge output stage
    always_ff @(negedge tck_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tdo_ff    <= 1'b0;
            tdo_oe_ff <= 1'b0;
        end else begin
            tdo_ff    <= nxt_tdo;
            tdo_oe_ff <= nxt_tdo_oe;
        end
    end

    assign tdo_o.tdo    = tdo_ff;
    assign tdo_o.tdo_oe = tdo_oe_ff;
    assign bsr_out_o    = upd_ff;

    // instruction levels and output enable cell crossed into the core domain, two flip-flops per level
    assign lvl_src = {ir_ff == `SBT_OP_EXTEST, upd_ff[`SBT_OE_CELL], ir_ff == `SBT_OP_SAMPLEZ};

    for (genvar g = 0; g < 3; g++) begin : g_sync
        logic [1:0] sync_ff, nxt_sync;

        always_comb begin
            nxt_sync = {sync_ff[0], lvl_src[g]};
        end

        always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                sync_ff <= {2{LVL_RST[g]}};
            end else begin
                sync_ff <= nxt_sync;
            end
        end

        assign lvl_q[g] = sync_ff[1];
    end

    assign ez_q = lvl_q[0];
    assign oe_q = lvl_q[1];
    assign tm_q = lvl_q[2];

    assign q_oe_o      = !ez_q && (!tm_q || oe_q);
    assign test_mode_o = tm_q;

    a_reset_ir_id: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        st_ff == ST_RESET |=> ir_ff == `SBT_OP_IDCODE) else $error("instruction not identification after reset");
    a_five_tms_rst: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        tms [*5] |=> st_ff == ST_RESET) else $error("five high mode select did not reset");
    a_ir_upd_only: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        (st_ff != ST_UPD_IR && st_ff != ST_RESET) |=> $stable(ir_ff)) else $error("instruction changed outside update");
    a_cap_ir_01: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        st_ff == ST_CAP_IR |=> ir_sh_ff[1:0] == 2'b01) else $error("capture ir pattern wrong");
    a_id_capture: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        (st_ff == ST_CAP_DR && ir_ff == `SBT_OP_IDCODE) |=> id_ff == ID_VALUE) else $error("id not captured");
    a_bsr_shift_in: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        (st_ff == ST_SH_DR && sel_bsr) |=> bsr_ff[BSR_W-1] == $past(tdi)) else $error("data-in not at msb");
    a_bypass_shift: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        (st_ff == ST_SH_DR && ir_ff == `SBT_OP_BYPASS) |=> byp_ff == $past(tdi)) else $error("bypass not shifting");
    a_bypass_clear: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        (st_ff == ST_CAP_DR && ir_ff == `SBT_OP_BYPASS) |=> !byp_ff) else $error("bypass not cleared");
    a_tdo_quiet: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        (st_ff == ST_IDLE && $past(st_ff) == ST_IDLE) |-> !tdo_o.tdo_oe) else $error("data-out driven when idle");
    a_samplez_float: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ez_q |-> !q_oe_o) else $error("output bus driven under sample z");

    // serial output checks, seen at the rising edge after the falling edge update
    a_tdo_oe_shift: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        (st_ff == ST_SH_IR || st_ff == ST_SH_DR) |-> tdo_o.tdo_oe)
        else $error("data-out not driven while shifting");
    a_tdo_ir_lsb: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        st_ff == ST_SH_IR |-> tdo_o.tdo == ir_sh_ff[0])
        else $error("instruction lsb not on data-out");
    a_tdo_byp_bit: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        (st_ff == ST_SH_DR && ir_ff == `SBT_OP_BYPASS) |-> tdo_o.tdo == byp_ff)
        else $error("bypass bit not on data-out");
    a_tdo_id_lsb: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        (st_ff == ST_SH_DR && ir_ff == `SBT_OP_IDCODE) |-> tdo_o.tdo == id_ff[0])
        else $error("id lsb not on data-out");
    a_tdo_bsr_lsb: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        (st_ff == ST_SH_DR && sel_bsr) |-> tdo_o.tdo == bsr_ff[0])
        else $error("boundary lsb not on data-out");

    // instruction register checks
    a_ir_shift_in: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        st_ff == ST_SH_IR |=> ir_sh_ff[`SBT_IR_W-1] == $past(tdi))
        else $error("data-in not at instruction msb");
    a_ir_update: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        st_ff == ST_UPD_IR |=> ir_ff == $past(ir_sh_ff))
        else $error("instruction not taken at update");

    // boundary, update and bypass register checks
    a_bsr_capture: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        (st_ff == ST_CAP_DR && sel_bsr) |=> bsr_ff == $past(pins_i))
        else $error("pin ring not captured");
    a_upd_latch: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        (st_ff == ST_UPD_DR && sel_bsr) |=> upd_ff == $past(bsr_ff))
        else $error("preload not latched at update");
    a_upd_hold: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        (st_ff != ST_UPD_DR && st_ff != ST_RESET) |=> $stable(upd_ff))
        else $error("preload changed outside update");
    a_reset_oe_cell: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        st_ff == ST_RESET |=> upd_ff[`SBT_OE_CELL])
        else $error("output enable cell not preset in reset");
    a_byp_hold: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        (st_ff != ST_CAP_DR && st_ff != ST_SH_DR) |=> $stable(byp_ff))
        else $error("bypass bit changed outside data states");

    // controller sequence checks
    a_reset_stay: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        (st_ff == ST_RESET && tms) |=> st_ff == ST_RESET)
        else $error("reset state left with mode select high");
    a_idle_stay: assert property (@(posedge tck_i) disable iff (!rst_n_i)
        (st_ff == ST_IDLE && !tms) |=> st_ff == ST_IDLE)
        else $error("idle state left with mode select low");
endmodule : sbt_tap

// *** sbt_ctl_model.sv ***
// test controller model driving the serial test link
`timescale 1ns/1ps
module sbt_ctl_model
    import sbt_pkg::*;
(
    // serial test link
    output logic     tck_o,
    output logic     tms_o,
    output logic     tms_oe_o,
    output logic     tdi_o,
    output logic     tdi_oe_o,
    input  sbt_tdo_t tdo_i
);
    logic tms_ff;
    logic tdi_ff;
    // a released line shows the inverse level, the pull-up is inside the port
    assign tms_o = tms_oe_o ? tms_ff : ~tms_ff;
    assign tdi_o = tdi_oe_o ? tdi_ff : ~tdi_ff;
    initial begin
        tck_o = 1'b0;
        tms_ff = 1'b1;
        tdi_ff = 1'b1;
        tms_oe_o = 1'b1;
        tdi_oe_o = 1'b1;
    end
    task automatic rel(input logic rt, input logic rd);
        tms_oe_o = ~rt;
        tdi_oe_o = ~rd;
    endtask : rel
    // one clock pulse; the clock stands low between steps
    task automatic step(input logic ms, input logic di, output logic so);
        tms_ff = ms;
        tdi_ff = di;
        #3;
        so = tdo_i.tdo;
        tck_o = 1'b1;
        #3;
        tck_o = 1'b0;
    endtask : step
    task automatic move(input logic [7:0] seq, input int n);
        logic so;
        for (int i = 0; i < n; i++) begin
            step(seq[i], 1'b1, so);
        end
    endtask : move
    task automatic dr(input int n, input logic [47:0] din, output logic [47:0] dout);
        dout = '0;
        move(8'h01, 3);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], dout[i]);
        end
        move(8'h01, 2);
    endtask : dr
    // any 3-bit code is loaded as given; the new code acts at update
    task automatic ir(input logic [2:0] code, output logic [2:0] cap);
        move(8'h03, 4);
        for (int i = 0; i < 3; i++) begin
            step(i == 2, code[i], cap[i]);
        end
        move(8'h01, 2);
    endtask : ir
endmodule : sbt_ctl_model

// *** testbench.sv ***
// self-checking bench for the memory boundary scan test port
`timescale 1ns/1ps
`include "sbt_params.svh"
module testbench;
    import sbt_pkg::*;
    localparam logic [47:0] ID = {16'h0, `SBT_ID_VERSION, `SBT_ID_PART, `SBT_ID_MAKER, 1'b1};
    logic        ref_clk_i = 1'b0;
    logic        rst_n_i   = 1'b0;
    logic [47:0] pins_i    = '0;
    logic        tck, tms, tms_oe, tdi, tdi_oe;
    sbt_tdo_t    tdo;
    logic [47:0] bsr_out;
    logic        q_oe;
    logic        test_mode;
    logic [47:0] q;
    logic [2:0]  c;
    int          err_total   = 0;
    int          checks_done = 0;
    always #2 ref_clk_i = ~ref_clk_i;
    sbt_tap sbt_tap_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .tck_i(tck), .tms_i(tms), .tms_oe_i(tms_oe),
        .tdi_i(tdi), .tdi_oe_i(tdi_oe), .tdo_o(tdo), .pins_i(pins_i), .bsr_out_o(bsr_out), .q_oe_o(q_oe),
        .test_mode_o(test_mode));
    sbt_ctl_model sbt_ctl_model_i (.tck_o(tck), .tms_o(tms), .tms_oe_o(tms_oe), .tdi_o(tdi), .tdi_oe_o(tdi_oe),
        .tdo_i(tdo));
    task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic settle();
        repeat (4) @(posedge ref_clk_i);
    endtask : settle
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    task automatic t_reset_id();
        chk("tdo enable after reset", 48'h0, tdo.tdo_oe);
        sbt_ctl_model_i.move(8'h00, 1);
        sbt_ctl_model_i.dr(32, 48'h0, q);
        chk("idcode", ID, q);
        chk("tdo enable in idle", 48'h0, tdo.tdo_oe);
        $display("test reset_id done");
    endtask : t_reset_id
    task automatic t_bypass();
        sbt_ctl_model_i.ir(`SBT_OP_BYPASS, c);
        chk("ir capture", 48'h1, c[1:0]);
        sbt_ctl_model_i.dr(8, 48'hA5, q);
        chk("bypass path", 48'h4A, q);
        $display("test bypass done");
    endtask : t_bypass
    task automatic t_samplez();
        @(posedge ref_clk_i) pins_i <= 48'h8123_4567_89AB;
        sbt_ctl_model_i.ir(`SBT_OP_SAMPLEZ, c);
        settle();
        chk("bus float", 48'h0, q_oe);
        sbt_ctl_model_i.dr(48, 48'h5A5A_C3C3, q);
        chk("boundary capture", 48'h8123_4567_89AB, q);
        chk("preload", 48'h5A5A_C3C3, bsr_out);
        sbt_ctl_model_i.ir(`SBT_OP_SAMPLE, c);
        settle();
        chk("bus driven under sample", 48'h1, q_oe);
        sbt_ctl_model_i.dr(48, 48'h0, q);
        chk("sample capture", 48'h8123_4567_89AB, q);
        $display("test samplez done");
    endtask : t_samplez
    task automatic t_extest();
        sbt_ctl_model_i.ir(`SBT_OP_EXTEST, c);
        settle();
        chk("extest mode", 48'h1, test_mode);
        chk("cell 47 low", 48'h0, q_oe);
        sbt_ctl_model_i.dr(48, 48'h8000_0000_0000, q);
        settle();
        chk("cell 47 high", 48'h1, q_oe);
        chk("extest capture", 48'h8123_4567_89AB, q);
        $display("test extest done");
    endtask : t_extest
    task automatic t_tms_reset();
        sbt_ctl_model_i.rel(1'b1, 1'b0);
        sbt_ctl_model_i.move(8'hFF, 5);
        settle();
        chk("enable after tms reset", 48'h1, q_oe);
        chk("mode after tms reset", 48'h0, test_mode);
        sbt_ctl_model_i.rel(1'b0, 1'b1);
        sbt_ctl_model_i.move(8'h00, 1);
        sbt_ctl_model_i.dr(40, 48'hFF_FFFF_FFFF, q);
        chk("idcode then pulled-up tdi", {8'h0, 8'hFF, ID[31:0]}, q);
        sbt_ctl_model_i.rel(1'b0, 1'b0);
        $display("test tms_reset done");
    endtask : t_tms_reset
    initial begin
        #200000;
        err_total++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge ref_clk_i);
        sbt_ctl_model_i.move(8'h01, 1);
        repeat (5) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        settle();
        t_reset_id();
        t_bypass();
        t_samplez();
        t_extest();
        t_tms_reset();
        print_verdict();
    end
endmodule : testbench
